//--- rsc_pkg.sv
/*
 * Shared constants and state types for the range-select command interpreter.
 * Assumes a 100 MHz system clock and a byte-addressed register port.
 */
package rsc_pkg;
   // Clock and background checksum timing
   localparam longint CLK_HZ       = 100_000_000;
   localparam longint CHK_TIME_S   = 30;
   localparam longint CHK_CYCLES   = CHK_TIME_S * CLK_HZ;

   // Register byte offsets
   localparam logic [7:0] OFS_KEY    = 8'h00;
   localparam logic [7:0] OFS_CUR    = 8'h04;
   localparam logic [7:0] OFS_VOLT   = 8'h08;
   localparam logic [7:0] OFS_EVENT  = 8'h0C;
   localparam logic [7:0] OFS_STATUS = 8'h10;
   localparam logic [7:0] OFS_CHKSUM = 8'h14;
   localparam logic [7:0] OFS_SERIAL = 8'h18;
   localparam logic [7:0] OFS_MODE   = 8'h1C;
   localparam logic [7:0] OFS_TIME   = 8'h20;
   localparam logic [7:0] OFS_ZSTD   = 8'h24;
   localparam logic [7:0] OFS_ZCFG   = 8'h28;
   localparam logic [7:0] OFS_ZDST   = 8'h2C;
   localparam logic [7:0] OFS_UTC    = 8'h30;
   localparam logic [7:0] OFS_UPTIME = 8'h34;
   localparam logic [7:0] OFS_SINCE  = 8'h38;
   localparam logic [7:0] OFS_ZNAME  = 8'h3C;

   // Field positions
   localparam int BIT_MISSING = 31;
   localparam int BIT_RUN_ERR = 4;
   localparam int BIT_CMD_ERR = 5;
   localparam int BIT_CHKDONE = 2;
   localparam int BIT_VERBOSE = 8;
   localparam int BIT_TVERB   = 31;
   localparam int POS_HH      = 16;
   localparam int POS_MM      = 8;
   localparam int POS_SS      = 0;
   localparam int BIT_DSTON   = 8;

   // Limits: current in microamps, voltage in millivolts
   localparam logic [30:0] CUR_MAX_UA  = 31'h0131_2D00;
   localparam logic [30:0] VOLT_MAX_MV = 31'h0000_D6D8;
   localparam logic [30:0] VOLT_MID_MV = 31'h0000_157C;
   localparam logic [17:0] SERIAL_MAX  = 18'h3_0D40;
   localparam logic [7:0]  ZONE_MIN    = 8'hE9;
   localparam logic [7:0]  ZONE_MAX    = 8'h18;

   // Key characters
   localparam logic [7:0] KEY_A = 8'h41;
   localparam logic [7:0] KEY_B = 8'h42;
   localparam logic [7:0] KEY_1 = 8'h31;
   localparam logic [7:0] KEY_6 = 8'h36;
   localparam logic [7:0] KEY_O = 8'h4F;
   localparam logic [7:0] KEY_R = 8'h52;

   // Reset values
   localparam logic [7:0]  RST_KEY     = 8'h3F;
   localparam logic [2:0]  RST_CUR_RNG = 3'h0;
   localparam logic [31:0] SUM_PENDING = 32'hFFFF_FFFF;

   typedef enum logic {SUM_RUN, SUM_DONE} rsc_sum_phase_type;

   typedef struct packed {
      logic [2:0]  s_tick;
      logic [2:0]  s_bat;
      logic        tick_lvl;
      logic        bat_lvl;
      logic        bat_done;
      logic        bat_load;
      logic [31:0] bat_secs;
      logic [2:0]  cur_rng;
      logic        vin_hi;
      logic [7:0]  last_key;
      logic        cmd_err;
      logic        run_err;
      logic        verbose;
      logic        chk_flag;
      logic        chk_seen;
      logic [17:0] serial;
      logic [4:0]  hh;
      logic [5:0]  mm;
      logic [5:0]  ss;
      logic [31:0] utc;
      logic [31:0] uptime;
      logic [31:0] since;
      logic [23:0] std_name;
      logic [23:0] dst_name;
      logic [7:0]  zone_off;
      logic        dst_on;
      logic [31:0] rdata;
   } rsc_state_type;
endpackage

//--- rsc_rom_sum.sv
/*
 * Background ROM checksum walker: sums every ROM word, paced so the walk
 * spans the configured time. Assumes a ROM with one cycle of read latency.
 */
`timescale 1ns/1ps
module rsc_rom_sum
   import rsc_pkg::*;
#(
   parameter int          ADDR_W = 12,
   parameter int          DATA_W = 8,
   parameter int unsigned PACE   = 4
) (
   input  wire logic              clk_in,
   input  wire logic              rst_n_in,
   input  wire logic [DATA_W-1:0] rom_data_in,
   output logic      [ADDR_W-1:0] rom_addr_out,
   output logic      [31:0]       sum_out,
   output logic                   done_out
);
   if (PACE < 2 || DATA_W > 32) begin : g_bad_param
      $error("rsc_rom_sum: PACE must be >= 2, DATA_W <= 32");
   end

   typedef struct packed {
      rsc_sum_phase_type phase;
      logic [31:0]       pace;
      logic [ADDR_W-1:0] addr;
      logic [31:0]       sum;
   } rsc_walk_type;

   rsc_walk_type q_r;
   rsc_walk_type q_nxt;

   always_comb begin
      q_nxt = q_r;
      case (q_r.phase)
         SUM_RUN: begin
            if (q_r.pace == 32'(PACE - 1)) begin
               q_nxt.pace = 32'h0;
               q_nxt.sum  = q_r.sum + 32'(rom_data_in);
               q_nxt.addr = q_r.addr + 1'b1;
               if (&q_r.addr) begin
                  q_nxt.phase = SUM_DONE;
               end
            end else begin
               q_nxt.pace = q_r.pace + 32'h1;
            end
         end
         default: begin
            q_nxt.phase = SUM_DONE;
         end
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         q_r <= '{SUM_RUN, 32'h0, '0, 32'h0};
      end else begin
         q_r <= q_nxt;
      end
   end

   assign rom_addr_out = q_r.addr;
   assign sum_out      = q_r.sum;
   assign done_out     = (q_r.phase == SUM_DONE);
endmodule

//--- rsc_interp.sv
/*
 * Range-select command interpreter: key entry, range selection, error flags,
 * reply mode, checksum status, serial number and seconds-based time keeping.
 * Assumes a same-clock register master and asynchronous tick and battery pins.
 */
// Added by the designer: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
module rsc_interp
   import rsc_pkg::*;
#(
   parameter longint CHK_CYCLES_P = CHK_CYCLES,
   parameter int     ROM_ADDR_W   = 12,
   parameter int     ROM_DATA_W   = 8
) (
   input  wire logic                  clk_in,
   input  wire logic                  rst_n_in,
   input  wire logic [7:0]            addr_in,
   input  wire logic [31:0]           wdata_in,
   input  wire logic                  wr_in,
   input  wire logic                  rd_in,
   output logic      [31:0]           rdata_out,
   input  wire logic                  tick_in,
   input  wire logic                  bat_valid_in,
   input  wire logic [31:0]           bat_secs_in,
   input  wire logic [16:0]           bat_tod_in,
   output logic                       bat_load_out,
   output logic      [31:0]           bat_secs_out,
   input  wire logic [ROM_DATA_W-1:0] rom_data_in,
   output logic      [ROM_ADDR_W-1:0] rom_addr_out,
   output logic      [2:0]            cur_range_out,
   output logic                       vin_range_hi_out,
   output logic                       verbose_out
);
   localparam longint SUM_PACE = CHK_CYCLES_P >> ROM_ADDR_W;

   if (SUM_PACE < 2 || SUM_PACE > 64'h7FFF_FFFF) begin : g_bad_pace
      $error("rsc_interp: CHK_CYCLES_P out of range");
   end

   // Nearest current range by arithmetic midpoints, value in microamps
   function automatic logic [2:0] nearest_cur(input logic [30:0] ua);
      if (ua < 31'h0000_044C) begin
         nearest_cur = 3'h0;
      end else if (ua < 31'h0000_2AF8) begin
         nearest_cur = 3'h1;
      end else if (ua < 31'h0001_ADB0) begin
         nearest_cur = 3'h2;
      end else if (ua < 31'h0010_C8E0) begin
         nearest_cur = 3'h3;
      end else if (ua < 31'h00A7_D8C0) begin
         nearest_cur = 3'h4;
      end else begin
         nearest_cur = 3'h5;
      end
   endfunction

   // Front-panel key characters that the interpreter accepts
   function automatic logic key_valid(input logic [7:0] k);
      key_valid = (k == KEY_A) || (k == KEY_B) || (k == KEY_O) || (k == KEY_R) || (k >= KEY_1 && k <= KEY_6);
   endfunction

   function automatic logic [16:0] tod_secs(input logic [4:0] h, input logic [5:0] m, input logic [5:0] s);
      tod_secs = 17'(h * 17'd3600) + 17'(m * 17'd60) + 17'(s);
   endfunction

   function automatic logic [4:0] mod24(input logic [7:0] v);
      logic [7:0] t;
      t = v;
      for (int i = 0; i < 5; i++) begin
         if (t >= 8'h18) t = t - 8'h18;
      end
      mod24 = t[4:0];
   endfunction

   rsc_state_type q_r;
   rsc_state_type q_nxt;

   logic [31:0] sum_val;
   logic        sum_done;

   rsc_rom_sum #(
      .ADDR_W (ROM_ADDR_W),
      .DATA_W (ROM_DATA_W),
      .PACE   (32'(SUM_PACE))
   ) rsc_rom_sum_inst (
      .clk_in       (clk_in),
      .rst_n_in     (rst_n_in),
      .rom_data_in  (rom_data_in),
      .rom_addr_out (rom_addr_out),
      .sum_out      (sum_val),
      .done_out     (sum_done)
   );

   logic [30:0] arg;
   logic        arg_missing;
   logic        tick_evt;
   logic [7:0]  loc_old;
   logic [7:0]  loc_new;
   logic [4:0]  th;
   logic [5:0]  tm;
   logic [5:0]  ts;

   assign arg         = wdata_in[30:0];
   assign arg_missing = wdata_in[BIT_MISSING];
   assign th          = wdata_in[POS_HH +: 5];
   assign tm          = wdata_in[POS_MM +: 6];
   assign ts          = wdata_in[POS_SS +: 6];
   assign tick_evt    = (q_r.s_tick[1] == q_r.s_tick[2]) && q_r.s_tick[2] && !q_r.tick_lvl;
   assign loc_old     = 8'(q_r.dst_on) - q_r.zone_off;
   assign loc_new     = 8'(wdata_in[BIT_DSTON]) - wdata_in[7:0];

   always_comb begin
      q_nxt          = q_r;
      q_nxt.bat_load = 1'b0;
      q_nxt.s_tick   = {q_r.s_tick[1:0], tick_in};
      q_nxt.s_bat    = {q_r.s_bat[1:0], bat_valid_in};
      if (q_r.s_tick[1] == q_r.s_tick[2]) q_nxt.tick_lvl = q_r.s_tick[2];
      if (q_r.s_bat[1] == q_r.s_bat[2]) q_nxt.bat_lvl = q_r.s_bat[2];

      // Running clock advances on each periodic tick
      if (tick_evt) begin
         q_nxt.utc    = q_r.utc + 32'h1;
         q_nxt.uptime = q_r.uptime + 32'h1;
         if (q_r.ss == 6'd59) begin
            q_nxt.ss = 6'h0;
            if (q_r.mm == 6'd59) begin
               q_nxt.mm = 6'h0;
               q_nxt.hh = (q_r.hh == 5'd23) ? 5'h0 : q_r.hh + 5'h1;
            end else begin
               q_nxt.mm = q_r.mm + 6'h1;
            end
         end else begin
            q_nxt.ss = q_r.ss + 6'h1;
         end
      end

      // Battery clock is taken at most once after each reset
      if (q_r.bat_lvl && !q_r.bat_done) begin
         q_nxt.bat_done = 1'b1;
         q_nxt.utc      = bat_secs_in;
         q_nxt.since    = bat_secs_in;
         q_nxt.hh       = bat_tod_in[16:12];
         q_nxt.mm       = bat_tod_in[11:6];
         q_nxt.ss       = bat_tod_in[5:0];
      end

      // Done flag clears on checksum read; the set below wins
      if (rd_in && addr_in == OFS_CHKSUM) q_nxt.chk_flag = 1'b0;
      if (sum_done && !q_r.chk_seen) begin
         q_nxt.chk_flag = 1'b1;
         q_nxt.chk_seen = 1'b1;
      end

      if (rd_in && addr_in == OFS_EVENT) begin
         q_nxt.cmd_err = 1'b0;
         q_nxt.run_err = 1'b0;
      end

      if (wr_in) begin
         if (addr_in == OFS_KEY) begin
            q_nxt.last_key = wdata_in[7:0];
            if (wdata_in[7:0] == KEY_A) begin
               q_nxt.vin_hi = 1'b0;
            end else if (wdata_in[7:0] == KEY_B) begin
               q_nxt.vin_hi = 1'b1;
            end else if (wdata_in[7:0] >= KEY_1 && wdata_in[7:0] <= KEY_6) begin
               q_nxt.cur_rng = 3'(wdata_in[7:0] - KEY_1);
            end else if (wdata_in[7:0] != KEY_O && wdata_in[7:0] != KEY_R) begin
               q_nxt.cmd_err  = 1'b1;
               q_nxt.last_key = q_r.last_key;
            end
         end else if (addr_in == OFS_CUR) begin
            if (arg_missing) begin
               q_nxt.cmd_err = 1'b1;
            end else if (arg > CUR_MAX_UA) begin
               q_nxt.run_err = 1'b1;
            end else begin
               q_nxt.cur_rng = nearest_cur(arg);
            end
         end else if (addr_in == OFS_VOLT) begin
            if (arg_missing) begin
               q_nxt.cmd_err = 1'b1;
            end else if (arg > VOLT_MAX_MV) begin
               q_nxt.run_err = 1'b1;
            end else begin
               q_nxt.vin_hi = (arg > VOLT_MID_MV);
            end
         end else if (addr_in == OFS_SERIAL) begin
            if (wdata_in > 32'(SERIAL_MAX)) begin
               q_nxt.run_err = 1'b1;
            end else begin
               q_nxt.serial = wdata_in[17:0];
            end
         end else if (addr_in == OFS_MODE) begin
            q_nxt.verbose = wdata_in[0];
         end else if (addr_in == OFS_TIME) begin
            if (th > 5'd23 || tm > 6'd59 || ts > 6'd59) begin
               q_nxt.run_err = 1'b1;
            end else begin
               q_nxt.hh       = th;
               q_nxt.mm       = tm;
               q_nxt.ss       = ts;
               q_nxt.utc      = q_r.utc - 32'(tod_secs(q_r.hh, q_r.mm, q_r.ss))
                              + 32'(tod_secs(th, tm, ts));
               q_nxt.bat_load = 1'b1;
               q_nxt.bat_secs = q_nxt.utc;
            end
         end else if (addr_in == OFS_ZSTD) begin
            q_nxt.std_name = wdata_in[23:0];
         end else if (addr_in == OFS_ZDST) begin
            q_nxt.dst_name = wdata_in[23:0];
         end else if (addr_in == OFS_ZCFG) begin
            if ($signed(wdata_in[7:0]) < $signed(ZONE_MIN) || $signed(wdata_in[7:0]) > $signed(ZONE_MAX)) begin
               q_nxt.run_err = 1'b1;
            end else begin
               q_nxt.zone_off = wdata_in[7:0];
               q_nxt.dst_on   = wdata_in[BIT_DSTON];
               q_nxt.hh       = mod24(8'(q_r.hh) + loc_new - loc_old + 8'h30);
            end
         end
      end

      // Read data stands in the cycle after the read strobe only
      q_nxt.rdata = 32'h0;
      if (rd_in) begin
         if (addr_in == OFS_KEY) begin
            q_nxt.rdata = {23'h0, q_r.verbose, q_r.last_key};
         end else if (addr_in == OFS_CUR) begin
            q_nxt.rdata = {23'h0, q_r.verbose, 5'h0, q_r.cur_rng};
         end else if (addr_in == OFS_VOLT) begin
            q_nxt.rdata = {23'h0, q_r.verbose, 7'h0, q_r.vin_hi};
         end else if (addr_in == OFS_EVENT) begin
            q_nxt.rdata = {26'h0, q_r.cmd_err, q_r.run_err, 4'h0};
         end else if (addr_in == OFS_STATUS) begin
            q_nxt.rdata = {23'h0, q_r.verbose, 5'h0, q_r.chk_flag, 2'h0};
         end else if (addr_in == OFS_CHKSUM) begin
            q_nxt.rdata = sum_done ? sum_val : SUM_PENDING;
         end else if (addr_in == OFS_SERIAL) begin
            q_nxt.rdata = {14'h0, q_r.serial};
         end else if (addr_in == OFS_MODE) begin
            q_nxt.rdata = {31'h0, q_r.verbose};
         end else if (addr_in == OFS_TIME) begin
            q_nxt.rdata = {q_r.verbose, 10'h0, q_r.hh, 2'h0, q_r.mm, 2'h0, q_r.ss};
         end else if (addr_in == OFS_ZSTD) begin
            q_nxt.rdata = {8'h0, q_r.std_name};
         end else if (addr_in == OFS_ZCFG) begin
            q_nxt.rdata = {23'h0, q_r.dst_on, q_r.zone_off};
         end else if (addr_in == OFS_ZDST) begin
            q_nxt.rdata = {8'h0, q_r.dst_name};
         end else if (addr_in == OFS_UTC) begin
            q_nxt.rdata = q_r.utc;
         end else if (addr_in == OFS_UPTIME) begin
            q_nxt.rdata = q_r.uptime;
         end else if (addr_in == OFS_SINCE) begin
            q_nxt.rdata = q_r.since;
         end else if (addr_in == OFS_ZNAME) begin
            q_nxt.rdata = {q_r.verbose, 7'h0, q_r.dst_on ? q_r.dst_name : q_r.std_name};
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         q_r          <= '0;
         q_r.cur_rng  <= RST_CUR_RNG;
         q_r.last_key <= RST_KEY;
      end else begin
         q_r <= q_nxt;
      end
   end

   assign rdata_out        = q_r.rdata;
   assign bat_load_out     = q_r.bat_load;
   assign bat_secs_out     = q_r.bat_secs;
   assign cur_range_out    = q_r.cur_rng;
   assign vin_range_hi_out = q_r.vin_hi;
   assign verbose_out      = q_r.verbose;

   chk_key_order: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      wr_in && addr_in == OFS_KEY && key_valid(wdata_in[7:0])
      |=> q_r.last_key == $past(wdata_in[7:0]))
      else $error("key not recorded");
   chk_key_b_range: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      wr_in && addr_in == OFS_KEY && wdata_in[7:0] == KEY_B |=> vin_range_hi_out)
      else $error("key B did not select 10 V");
   chk_key_6_range: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      wr_in && addr_in == OFS_KEY && wdata_in[7:0] == KEY_6 |=> cur_range_out == 3'h5)
      else $error("key 6 did not select 20 A");
   chk_cur_nearest: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      wr_in && addr_in == OFS_CUR && !arg_missing && arg <= CUR_MAX_UA
      |=> cur_range_out == nearest_cur($past(arg)))
      else $error("current range not nearest");
   chk_arg_missing: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      wr_in && (addr_in == OFS_CUR || addr_in == OFS_VOLT) && arg_missing |=> q_r.cmd_err)
      else $error("missing value did not set command error");
   chk_cur_over: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      wr_in && addr_in == OFS_CUR && !arg_missing && arg > CUR_MAX_UA
      |=> q_r.run_err && $stable(cur_range_out))
      else $error("over-range current not flagged");
   chk_volt_near: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      wr_in && addr_in == OFS_VOLT && !arg_missing && arg <= VOLT_MAX_MV
      |=> vin_range_hi_out == ($past(arg) > VOLT_MID_MV))
      else $error("voltage range not nearest");
   chk_volt_over: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      wr_in && addr_in == OFS_VOLT && !arg_missing && arg > VOLT_MAX_MV |=> q_r.run_err)
      else $error("over-range voltage not flagged");
   chk_sum_pending: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      rd_in && addr_in == OFS_CHKSUM && !sum_done |=> rdata_out == SUM_PENDING)
      else $error("checksum read before done not -1");
   chk_flag_once: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      q_r.chk_seen && !q_r.chk_flag |=> !q_r.chk_flag)
      else $error("checksum flag set twice");
   chk_serial_store: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      wr_in && addr_in == OFS_SERIAL && wdata_in <= 32'(SERIAL_MAX)
      |=> q_r.serial == $past(wdata_in[17:0]))
      else $error("serial number not stored");
   chk_terse_reset: assert property (@(posedge clk_in)
      !rst_n_in |=> !verbose_out)
      else $error("not terse after reset");
   chk_uptime_tick: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      tick_evt |=> q_r.uptime == $past(q_r.uptime) + 32'h1)
      else $error("uptime did not advance");
   chk_key_refused: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      wr_in && addr_in == OFS_KEY && !key_valid(wdata_in[7:0])
      |=> q_r.cmd_err && $stable(q_r.last_key))
      else $error("unknown key not refused");
   chk_time_load: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      wr_in && addr_in == OFS_TIME && th <= 5'd23 && tm <= 6'd59 && ts <= 6'd59
      |=> bat_load_out && q_r.hh == $past(th))
      else $error("set time did not load clocks");
endmodule

//--- rsc_rom_model.sv
/* ROM model for the checksum walker.
   Assumes one clock and one cycle of read latency. */
`timescale 1ns/1ps
module rsc_rom_model (
   input  wire logic       clk_in,
   input  wire logic [3:0] addr_in,
   output logic      [7:0] data_out
);
   always @(posedge clk_in) begin
      data_out <= {addr_in, ~addr_in};
   end
endmodule

//--- test_range_select_command_interpreter.sv
/* Self-checking bench for rsc_interp with a 16-word ROM and a short walk.
   Assumes rsc_pkg and the ROM model are compiled first. */
`timescale 1ns/1ps
module test_range_select_command_interpreter;
   import rsc_pkg::*;
   logic        clk_in = 0, rst_n_in = 0, wr_in = 0, rd_in = 0, rd_q = 0, done = 0;
   logic [7:0]  addr_in = 0, rom_data;
   logic [31:0] wdata_in = 0, rdata_out, v, e;
   logic [32:0] x, q[$];
   logic [3:0]  rom_addr;
   logic [2:0]  cur_range_out;
   logic        vin_range_hi_out, verbose_out;
   logic        tick = 0, bat_v = 0, bat_load;
   logic [31:0] bat_s = 0, bat_secs;
   logic [16:0] bat_t = 0;
   int          mismatches = 0, comparisons = 0;
   int          mids[5] = '{1100, 11000, 110000, 1100000, 11000000};
   int          vv[4] = '{5500, 5501, 55000, 1};
   always #5 clk_in = ~clk_in;
   rsc_interp #(.CHK_CYCLES_P(64), .ROM_ADDR_W(4), .ROM_DATA_W(8)) rsc_interp_inst (
      .clk_in, .rst_n_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
      .tick_in(tick), .bat_valid_in(bat_v), .bat_secs_in(bat_s), .bat_tod_in(bat_t),
      .bat_load_out(bat_load), .bat_secs_out(bat_secs), .rom_data_in(rom_data), .rom_addr_out(rom_addr),
      .cur_range_out, .vin_range_hi_out, .verbose_out);
   rsc_rom_model rsc_rom_model_inst (.clk_in, .addr_in(rom_addr), .data_out(rom_data));
   task chk(input string n, input logic [31:0] xp, g);
      comparisons++;
      if (g !== xp) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", n, xp, g);
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_in);
      wr_in <= 1; rd_in <= 0; addr_in <= a; wdata_in <= d;
   endtask
   task rd(input logic [7:0] a, input logic [32:0] xp);
      @(posedge clk_in);
      rd_in <= 1; wr_in <= 0; addr_in <= a; q.push_back(xp);
   endtask
   task idle;
      @(posedge clk_in);
      wr_in <= 0; rd_in <= 0; #1;
   endtask
   task results;
      if (q.size() != 0) mismatches++;
      $display("mismatches %0d comparisons %0d", mismatches, comparisons);
      if (mismatches == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // Read data belongs to the read taken one edge earlier
   always @(posedge clk_in) begin
      if (rd_q) begin
         x = q.pop_front();
         if (!x[32]) chk("rdata", x[31:0], rdata_out);
      end
      rd_q <= rd_in;
   end
   initial begin
      void'($urandom(32'h9361));
      repeat (20) @(posedge clk_in);
      rst_n_in <= 1;
      @(posedge clk_in);
      rd(OFS_KEY, 33'h3F); rd(OFS_CUR, 0); rd(OFS_VOLT, 0); rd(OFS_MODE, 0);
      rd(OFS_CHKSUM, 33'hFFFF_FFFF); rd(OFS_STATUS, 0);
      wr(OFS_KEY, 32'h42); wr(OFS_KEY, 32'h36); idle;
      chk("cur", 5, cur_range_out); chk("vin", 1, vin_range_hi_out);
      rd(OFS_KEY, 33'h36); wr(OFS_KEY, 32'h41); wr(OFS_KEY, 32'h31); idle;
      chk("cur", 0, cur_range_out); chk("vin", 0, vin_range_hi_out);
      for (int i = 0; i < 200 && !done; i++) begin
         rd(OFS_STATUS, 33'h1_0000_0000); idle; done = rdata_out[2];
      end
      if (!done) begin chk("walk", 1, 0); results; end
      e = 0;
      for (int a = 0; a < 16; a++) e += {a[3:0], ~a[3:0]};
      rd(OFS_CHKSUM, {1'b0, e}); rd(OFS_STATUS, 0);
      for (int i = 0; i < 24; i++) begin
         v = (i == 0) ? 0 : (i == 1) ? 20000000 : (i == 2) ? 1099 : (i == 3) ? 1100 : $urandom % 20000001;
         e = 0;
         foreach (mids[k]) if (v >= mids[k]) e++;
         wr(OFS_CUR, v); idle; chk("cur", e, cur_range_out);
      end
      wr(OFS_CUR, 20000001); wr(OFS_CUR, 32'h8000_0000); idle; chk("cur", e, cur_range_out);
      rd(OFS_EVENT, 33'h30); rd(OFS_EVENT, 0);
      foreach (vv[i]) begin
         wr(OFS_VOLT, vv[i]); idle; chk("vin", 32'(vv[i] > 5500), vin_range_hi_out);
      end
      wr(OFS_VOLT, 55001); wr(OFS_VOLT, 32'h8000_0000); rd(OFS_EVENT, 33'h30);
      wr(OFS_SERIAL, 200000); wr(OFS_SERIAL, 200001); rd(OFS_SERIAL, 200000);
      rd(OFS_EVENT, 33'h10); wr(OFS_MODE, 1); rd(OFS_CUR, {1'b0, e | 32'h100});
      rd(OFS_VOLT, 33'h100); rd(OFS_STATUS, 33'h100); idle; chk("verbose", 1, verbose_out);
      wr(OFS_MODE, 0); rd(OFS_KEY, 33'h31); rd(OFS_MODE, 0);
      wr(OFS_KEY, 32'h4F); wr(OFS_KEY, 32'h5A); rd(OFS_KEY, 33'h4F); rd(OFS_EVENT, 33'h20); idle;
      @(posedge clk_in) begin bat_s <= $urandom; bat_t <= {5'd23, 6'd59, 6'd58}; bat_v <= 1; end
      repeat (6) idle;
      rd(OFS_SINCE, {1'b0, bat_s}); rd(OFS_UTC, {1'b0, bat_s}); rd(OFS_TIME, 33'h0017_3B3A); idle;
      for (int i = 0; i < 4; i++) begin
         @(posedge clk_in) tick <= !tick;
         repeat (6) idle;
      end
      e = bat_s + 32'd2;
      rd(OFS_TIME, 0); rd(OFS_UPTIME, 2); rd(OFS_UTC, {1'b0, e});
      e = e + 32'd45005;
      wr(OFS_TIME, 32'h000C_1E05); idle; chk("bat_load", 1, bat_load); chk("bat_secs", e, bat_secs);
      idle; chk("bat_load", 0, bat_load);
      wr(OFS_TIME, 32'h0018_0000); wr(OFS_ZSTD, 32'h45_5354); wr(OFS_ZDST, 32'h45_4454);
      wr(OFS_ZCFG, 32'h0000_0105); wr(OFS_ZCFG, 32'h19); rd(OFS_EVENT, 33'h10);
      rd(OFS_TIME, 33'h0008_1E05); rd(OFS_ZCFG, 33'h105); rd(OFS_UTC, {1'b0, e});
      wr(OFS_MODE, 1); rd(OFS_ZNAME, 33'h8045_4454); rd(OFS_TIME, 33'h8008_1E05); idle;
      @(posedge clk_in) rst_n_in <= 0;
      repeat (3) idle;
      @(posedge clk_in) rst_n_in <= 1;
      idle; chk("verbose", 0, verbose_out);
      rd(OFS_UPTIME, 0); rd(OFS_CHKSUM, 33'hFFFF_FFFF); rd(OFS_CUR, 0);
      repeat (3) idle;
      results;
   end
endmodule
